// ---- verilog/chgpc_top.sv ----
// Chosen here: the placing of the registers and register access over APB.
`timescale 1ns/1ns
`default_nettype none
module chgpc_top #(
    parameter int BLINK_CYC = chgpc_pkg::BLINK_HALF_CYC,
    parameter int PULSE_CYC = chgpc_pkg::INT_PULSE_CYC,
    parameter int WAKE_CYC = chgpc_pkg::WAKE_HOLD_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic charge_enable_n,
    input wire logic source_select_in,
    input wire logic limit_select_boost_pin,
    input wire logic ship_wake_pin,
    input wire logic [11:0] input_limit_resistor_pin,
    input wire logic [1:0] data_contact_detect,
    input wire chgpc_pkg::chgpc_sense_s sense,
    output logic status_out_oe,
    output logic status_out_o,
    output logic int_out_oe,
    output logic int_out_o,
    output logic input_good_out,
    output logic battery_switch,
    output logic [11:0] input_current_limit,
    output chgpc_pkg::chgpc_ctrl_s ctrl
);
    import chgpc_pkg::*;

    // Refuse a blink half under two cycles, or an empty pulse or wake hold
    if (BLINK_CYC < 2 || PULSE_CYC < 1 || WAKE_CYC < 1) begin : g_bad_cnt
        $error("chgpc_top: counts too small");
    end

    // Software registers
    logic [7:0] src_ctrl_ff;
    logic [7:0] pwr_cfg_ff;
    logic [7:0] misc_ctrl_ff;
    // Charge phase and pin state
    chgpc_phase_e phase_ff;
    // Counters are 32 bits so the full-rate counts fit
    logic [31:0] blink_cnt_ff;
    logic blink_ff;
    logic [31:0] pulse_cnt_ff;
    logic [31:0] wake_cnt_ff;
    logic wake_prev_ff;
    logic wake_arm_ff;
    logic ship_ff;
    logic [7:0] evt_prev_ff;
    logic evt_pend_ff;

    // APB strobes: zero wait state
    // Read decodes in setup so data stands through access
    logic apb_wr;
    logic apb_rd;
    assign apb_wr = psel && penable && pwrite;
    assign apb_rd = psel && !penable && !pwrite;

    // Effective limits and qualifiers
    // All combinational; the outputs below register them
    logic charge_allowed;
    logic boost_req;
    logic usb_host;
    logic [11:0] src_limit;
    logic [11:0] prog_limit;
    logic [11:0] nxt_limit;
    logic good_window;
    logic [7:0] evt_now;

    // Source kind: select pin, or data-line result when nonzero
    // Detection, when it has a result, outranks the select pin
    always_comb begin
        usb_host = source_select_in;
        if (data_contact_detect != 2'b00) begin
            usb_host = (data_contact_detect == 2'b01);
        end
    end

    // Programmed limit from three-bit field
    // Eight steps; the top code gives the highest limit
    always_comb begin
        case (src_ctrl_ff[2:0])
            3'd0: prog_limit = 12'd100;
            3'd1: prog_limit = 12'd150;
            3'd2: prog_limit = 12'd500;
            3'd3: prog_limit = 12'd900;
            3'd4: prog_limit = 12'd1000;
            3'd5: prog_limit = 12'd1500;
            3'd6: prog_limit = 12'd2000;
            default: prog_limit = 12'd3000;
        endcase
    end

    // USB host sets the limit from the select pin, in place of the programmed value
    // Resistor and the source limit compete; the lower wins
    always_comb begin
        src_limit = prog_limit;
        if (usb_host) begin
            src_limit = limit_select_boost_pin ? USB_HI_MA
                                               : USB_LO_MA;
        end
        if (input_limit_resistor_pin < src_limit) begin
            nxt_limit = input_limit_resistor_pin;
        end else begin
            nxt_limit = src_limit;
        end
    end

    // Qualifiers for charge and boost
    // Thermistor window gates both directions of power flow
    // Ship mode blocks charging: the battery path is open
    assign charge_allowed = (pwr_cfg_ff[5:4] == MODE_CHARGE)
                            && !charge_enable_n
                            && sense.ts_in_window
                            && !ship_ff;
    assign boost_req = pwr_cfg_ff[CFG_BOOST_BIT]
                       && limit_select_boost_pin
                       && sense.ts_in_window;
    assign good_window = sense.vin_above_input_undervoltage_threshold && sense.vin_below_ovp
                         && sense.vin_above_sleep
                         && (nxt_limit > PG_MIN_MA);

    // Register writes
    // Writes land at the access edge only; upper bits are dropped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_ctrl_ff <= SRC_CTRL_RST;
            pwr_cfg_ff <= PWR_CFG_RST;
            misc_ctrl_ff <= MISC_CTRL_RST;
        end else if (apb_wr) begin
            case (paddr)
                OFS_SRC_CTRL: src_ctrl_ff <= pwdata[7:0];
                OFS_PWR_CFG: pwr_cfg_ff <= pwdata[7:0];
                OFS_MISC_CTRL: misc_ctrl_ff <= pwdata[7:0];
                default: ;
            endcase
        end
    end

    // Read data, registered in setup so it is valid in access
    // Unmapped reads return zero rather than stale data
    // Status: phase 14:12, ship 11, fault 10, good 9, boost 8
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (apb_rd) begin
            case (paddr)
                OFS_SRC_CTRL: prdata <= {24'h0, src_ctrl_ff};
                OFS_PWR_CFG: prdata <= {24'h0, pwr_cfg_ff};
                OFS_MISC_CTRL: prdata <= {24'h0, misc_ctrl_ff};
                OFS_STATUS: prdata <= {16'h0, 1'b0, phase_ff,
                                       ship_ff, sense.fault,
                                       input_good_out, boost_req,
                                       8'h0};
                default: prdata <= 32'h0;
            endcase
        end
    end

    // Ready in each access cycle only; unmapped address flags an error in access
    // No wait states: the answer is fixed one cycle after setup
    // Writing the read-only status word is refused too
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && paddr != OFS_SRC_CTRL
                       && paddr != OFS_PWR_CFG
                       && paddr != OFS_MISC_CTRL
                       && !(paddr == OFS_STATUS && !pwrite);
        end
    end

    // Autonomous charge cycle sequencing
    // Losing any qualifier drops back to idle at once
    // Recharge restarts at preconditioning, never mid-cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_ff <= CHGPC_IDLE;
        end else if (!charge_allowed) begin
            phase_ff <= CHGPC_IDLE;
        end else begin
            case (phase_ff)
                CHGPC_IDLE: phase_ff <= CHGPC_PRE;
                CHGPC_PRE: begin
                    if (sense.bat_above_lowv) begin
                        phase_ff <= CHGPC_CC;
                    end
                end
                CHGPC_CC: begin
                    if (sense.bat_at_reg) begin
                        phase_ff <= CHGPC_CV;
                    end
                end
                CHGPC_CV: begin
                    if (sense.ichg_below_term) begin
                        phase_ff <= CHGPC_DONE;
                    end
                end
                CHGPC_DONE: begin
                    if (sense.bat_below_rechg) begin
                        phase_ff <= CHGPC_PRE;
                    end
                end
                default: phase_ff <= CHGPC_IDLE;
            endcase
        end
    end

    // Fault blink timebase, equal halves
    // Counter parks with no fault so a new fault starts clean
    // Limitation: a fault shorter than one half never shows
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            blink_cnt_ff <= 32'h0;
            blink_ff <= 1'b0;
        end else if (!sense.fault) begin
            blink_cnt_ff <= 32'h0;
            blink_ff <= 1'b0;
        end else if (blink_cnt_ff == 32'(BLINK_CYC - 1)) begin
            blink_cnt_ff <= 32'h0;
            blink_ff <= !blink_ff;
        end else begin
            blink_cnt_ff <= blink_cnt_ff + 32'h1;
        end
    end

    // Status pin drive: enable high pulls the pin low
    // Fault blink overrides the normal charge indication
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_out_oe <= 1'b0;
        end else if (sense.fault) begin
            status_out_oe <= blink_ff;
        end else begin
            status_out_oe <= (phase_ff == CHGPC_PRE)
                             || (phase_ff == CHGPC_CC)
                             || (phase_ff == CHGPC_CV);
        end
    end
    assign status_out_o = 1'b0;
    assign int_out_o = 1'b0;

    // Events watched for status change
    // Top bit spare; every phase step counts as an event
    assign evt_now = {1'b0, sense.fault, input_good_out, boost_req,
                      ship_ff, phase_ff};

    // Interrupt pulse; an event during a pulse waits, not lost
    // Trade-off: one pending flag, so a burst of changes
    // during a pulse merges into a single extra pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evt_prev_ff <= 8'h0;
            evt_pend_ff <= 1'b0;
            pulse_cnt_ff <= 32'h0;
            int_out_oe <= 1'b0;
        end else begin
            evt_prev_ff <= evt_now;
            if (pulse_cnt_ff != 32'h0) begin
                pulse_cnt_ff <= pulse_cnt_ff - 32'h1;
                if (evt_now != evt_prev_ff) begin
                    evt_pend_ff <= 1'b1;
                end
                if (pulse_cnt_ff == 32'h1) begin
                    int_out_oe <= 1'b0;
                end
            end else if (evt_now != evt_prev_ff || evt_pend_ff) begin
                pulse_cnt_ff <= 32'(PULSE_CYC);
                int_out_oe <= 1'b1;
                evt_pend_ff <= 1'b0;
            end
        end
    end

    // Wake pin qualification and ship mode
    // Pin is synchronous, so no extra stage; count saturates
    // A write entering ship mode wins over a wake that edge
    // Clearing the switch-off bit also leaves ship mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_prev_ff <= 1'b0;
            wake_arm_ff <= 1'b0;
            wake_cnt_ff <= 32'h0;
            ship_ff <= 1'b0;
        end else begin
            wake_prev_ff <= ship_wake_pin;
            if (!ship_wake_pin) begin
                wake_arm_ff <= 1'b0;
                wake_cnt_ff <= 32'h0;
            end else if (!wake_prev_ff) begin
                wake_arm_ff <= 1'b1;
                wake_cnt_ff <= 32'h1;
            end else if (wake_arm_ff && wake_cnt_ff
                         < 32'(WAKE_CYC)) begin
                wake_cnt_ff <= wake_cnt_ff + 32'h1;
            end
            if (apb_wr && paddr == OFS_MISC_CTRL
                && pwdata[MISC_SWOFF_BIT]) begin
                ship_ff <= 1'b1;
            end else if (wake_arm_ff
                         && wake_cnt_ff == 32'(WAKE_CYC)) begin
                ship_ff <= 1'b0;
            end else if (!misc_ctrl_ff[MISC_SWOFF_BIT]) begin
                ship_ff <= 1'b0;
            end
        end
    end

    // Battery switch and limit outputs
    // Reset leaves the switch closed so the system stays fed
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            battery_switch <= 1'b1;
            input_good_out <= 1'b1;
            input_current_limit <= USB_LO_MA;
        end else begin
            battery_switch <= !ship_ff;
            input_good_out <= !good_window;
            input_current_limit <= nxt_limit;
        end
    end

    // Commands to the analog loops
    // Supplement follows zero charge by one cycle, never first
    // Phase code is the low two bits; done and idle share zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= '0;
            ctrl.sysmin_code <= SYSMIN_RST;
        end else begin
            ctrl.charge_en <= charge_allowed
                              && phase_ff != CHGPC_DONE
                              && phase_ff != CHGPC_IDLE;
            ctrl.boost_en <= boost_req;
            ctrl.thermal_reduce <= sense.jtemp_over;
            ctrl.chg_zero <= sense.in_limit_hit;
            ctrl.supplement <= sense.in_limit_hit
                               && ctrl.chg_zero;
            ctrl.chg_phase <= phase_ff[1:0];
            ctrl.sysmin_code <= pwr_cfg_ff[3:1];
        end
    end
endmodule
`default_nettype wire

// ---- verilog/chgpc_pkg.sv ----
package chgpc_pkg;
    // Clock rate and derived timebase
    localparam int CLK_FREQ_HZ = 250000000;
    localparam int CLK_PERIOD_NS = 4;
    // Fault blink rate and half period count
    localparam int BLINK_HZ = 1;
    localparam int BLINK_HALF_CYC = CLK_FREQ_HZ / (2 * BLINK_HZ);
    // Interrupt pulse width
    localparam int INT_PULSE_US = 256;
    localparam int INT_PULSE_CYC = INT_PULSE_US * 1000 / CLK_PERIOD_NS;
    // Wake pin minimum high time
    localparam int WAKE_HOLD_MS = 2;
    localparam int WAKE_HOLD_CYC = WAKE_HOLD_MS * 1000000 / CLK_PERIOD_NS;
    // Power-good current floor in mA
    localparam logic [11:0] PG_MIN_MA = 12'd30;
    // USB host limits in mA
    localparam logic [11:0] USB_HI_MA = 12'd500;
    localparam logic [11:0] USB_LO_MA = 12'd100;
    // Register offsets (byte addresses)
    localparam logic [7:0] OFS_SRC_CTRL = 8'h00;
    localparam logic [7:0] OFS_PWR_CFG = 8'h04;
    localparam logic [7:0] OFS_MISC_CTRL = 8'h1C;
    localparam logic [7:0] OFS_STATUS = 8'h20;
    // Field positions
    localparam int CFG_BOOST_BIT = 4;
    localparam int MISC_SWOFF_BIT = 5;
    localparam logic [1:0] MODE_CHARGE = 2'b01;
    // Reset values
    localparam logic [7:0] SRC_CTRL_RST = 8'h07;
    localparam logic [7:0] PWR_CFG_RST = 8'h1B;
    localparam logic [7:0] MISC_CTRL_RST = 8'h00;
    localparam logic [2:0] JTEMP_RST = 3'h3;
    localparam logic [2:0] SYSMIN_RST = 3'h5;

    // Charge cycle phases
    typedef enum logic [2:0] {
        CHGPC_IDLE, CHGPC_PRE, CHGPC_CC, CHGPC_CV, CHGPC_DONE
    } chgpc_phase_e;

    // Analog comparator results bundled together
    typedef struct packed {
        logic vin_above_input_undervoltage_threshold;
        logic vin_below_ovp;
        logic vin_above_sleep;
        logic bat_above_lowv;
        logic bat_at_reg;
        logic ichg_below_term;
        logic bat_below_rechg;
        logic ts_in_window;
        logic jtemp_over;
        logic in_limit_hit;
        logic fault;
    } chgpc_sense_s;

    // Commands to the analog loops
    typedef struct packed {
        logic charge_en;
        logic boost_en;
        logic thermal_reduce;
        logic supplement;
        logic chg_zero;
        logic [1:0] chg_phase;
        logic [2:0] sysmin_code;
    } chgpc_ctrl_s;
endpackage

// ---- verif/chgpc_monitor.sv ----
`timescale 1ns/1ns
`default_nettype none
// Pin and loop-command checks on the top's ports
module chgpc_monitor #(
    parameter int BLINK_CYC = 8,
    parameter int PULSE_CYC = 4,
    parameter int WAKE_CYC = 10
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic charge_enable_n,
    input wire logic limit_select_boost_pin,
    input wire logic ship_wake_pin,
    input wire logic [11:0] input_limit_resistor_pin,
    input wire chgpc_pkg::chgpc_sense_s sense,
    input wire logic status_out_oe,
    input wire logic int_out_oe,
    input wire logic input_good_out,
    input wire logic battery_switch,
    input wire logic [11:0] input_current_limit,
    input wire chgpc_pkg::chgpc_ctrl_s ctrl
);
    import chgpc_pkg::*;
    logic [7:0] int_ff; // Cycles the interrupt has been low
    logic [7:0] st_ff; // Length of the current status level
    logic [7:0] flt_ff; // Cycles fault has stood, saturating
    logic [7:0] wake_ff; // Cycles wake pin has stood high
    logic prev_ff; // Status level one sample back
    // Run-length counters; flt_ff and wake_ff saturate, int_ff and st_ff can wrap
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_ff <= 8'h00;
            st_ff <= 8'h00;
            flt_ff <= 8'h00;
            wake_ff <= 8'h00;
            prev_ff <= 1'b0;
        end else begin
            int_ff <= int_out_oe ? int_ff + 8'h01 : 8'h00;
            prev_ff <= status_out_oe;
            st_ff <= (status_out_oe != prev_ff) ? 8'h01 : st_ff + 8'h01;
            flt_ff <= !sense.fault ? 8'h00 : flt_ff + {7'h00, !(&flt_ff)};
            wake_ff <= !ship_wake_pin ? 8'h00 : wake_ff + {7'h00, !(&wake_ff)};
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Lag of two samples allows one register stage in the design
    a_apb_no_wait: assert property (psel && !penable |=> pready && penable)
        else $error("no answer in access cycle");
    a_chg_pin_off: assert property (
        charge_enable_n [*2] |-> !ctrl.charge_en)
        else $error("charging with enable high");
    a_boost_pin_off: assert property (
        !limit_select_boost_pin [*2] |-> !ctrl.boost_en)
        else $error("boost with select pin low");
    a_ts_stops_all: assert property (!sense.ts_in_window [*2]
        |-> !ctrl.charge_en && !ctrl.boost_en) else $error("ts window ignored");
    a_int_width: assert property ($fell(int_out_oe)
        |-> int_ff != 8'h00 && int_ff % PULSE_CYC == 0) else $error("bad pulse");
    a_blink_period: assert property (
        flt_ff > 8'd20 && $changed(status_out_oe) |-> st_ff == BLINK_CYC)
        else $error("blink half period wrong");
    a_good_window: assert property (
        !(sense.vin_above_input_undervoltage_threshold && sense.vin_below_ovp && sense.vin_above_sleep)
        [*2] |-> input_good_out) else $error("input good outside window");
    a_limit_lower: assert property (
        $stable(input_limit_resistor_pin) [*2]
        |-> input_current_limit <= input_limit_resistor_pin)
        else $error("limit above resistor");
    a_wake_hold: assert property ($rose(battery_switch) && !$past(psel)
        && !$past(psel, 2) |-> wake_ff >= WAKE_CYC - 1) else $error("early wake");
    a_supp_order: assert property (
        $rose(ctrl.supplement) |-> $past(ctrl.chg_zero))
        else $error("supplement before zero charge");
endmodule
bind chgpc_top chgpc_monitor #(.BLINK_CYC(BLINK_CYC), .PULSE_CYC(PULSE_CYC),
    .WAKE_CYC(WAKE_CYC)) u_mon (.*);
`default_nettype wire

// ---- verif/chgpc_host.sv ----
`timescale 1ns/1ns
`default_nettype none
// Host processor: pull-ups on the open-drain pins, drives control pins
module chgpc_host (
    input wire logic pclk,
    input wire logic status_out_oe,
    input wire logic int_out_oe,
    input wire logic charge_req,
    output logic charge_enable_n,
    output logic ship_wake_pin,
    output logic status_line,
    output logic int_line
);
    int int_cnt; // Interrupt pulses seen
    int int_w; // Width of the last pulse
    int run; // Low cycles of the pulse in flight
    int stat_edges; // Status line transitions
    logic int_prev, stat_prev; // Last sampled levels
    // Released lines float up to the rail
    assign status_line = status_out_oe ? 1'b0 : 1'b1;
    assign int_line = int_out_oe ? 1'b0 : 1'b1;
    // Always a firm level, never left open
    assign charge_enable_n = !charge_req;
    // Pull-down keeps the wake pin low when idle
    initial ship_wake_pin = 1'b0;
    // Pulse and edge counting
    always @(posedge pclk) begin
        int_prev <= int_line;
        stat_prev <= status_line;
        if (int_line === 1'b0)
            run <= run + 1;
        if (int_line === 1'b1 && int_prev === 1'b0) begin
            int_cnt <= int_cnt + 1;
            int_w <= run;
            run <= 0;
        end
        if (status_line !== stat_prev)
            stat_edges <= stat_edges + 1;
    end
    task automatic clr();
        int_cnt <= 0;
        stat_edges <= 0;
    endtask
    // Rising edge, then high for n cycles
    task automatic wake(input int n);
        ship_wake_pin <= 1'b1;
        repeat (n) @(posedge pclk);
        ship_wake_pin <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ---- verif/tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import chgpc_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, charge_req = 1'b0, serr;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, pslverr, charge_enable_n, ship_wake_pin;
    logic status_line, int_line, status_out_oe, status_out_o;
    logic int_out_oe, int_out_o, input_good_out, battery_switch;
    logic source_select_in = 1'b1, limit_select_boost_pin = 1'b0;
    logic [11:0] input_limit_resistor_pin = 12'h5DC, input_current_limit;
    logic [1:0] data_contact_detect = 2'h0;
    chgpc_sense_s sense = '0;
    chgpc_ctrl_s ctrl;
    int err_total = 0, comparisons = 0, cyc = 0;
    // Short counts keep the run brief
    chgpc_top #(.BLINK_CYC(8), .PULSE_CYC(4), .WAKE_CYC(10)) dut (.*);
    chgpc_host host (.*);
    always #2 pclk = ~pclk;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        $display("%0d compared, %0d wrong", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // One APB transfer; holds until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // Drive source pins, let it settle, compare the limit
    task automatic lim(input logic [1:0] d, input logic s, input logic p,
        input logic [11:0] e);
        data_contact_detect <= d;
        source_select_in <= s;
        limit_select_boost_pin <= p;
        step(4);
        chk(input_current_limit, e);
    endtask
    // Hang guard
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            test_done();
        end
    end
    initial begin
        step(20);
        presetn <= 1'b1;
        step(1);
        chk(battery_switch, 1);
        chk(ctrl.sysmin_code, SYSMIN_RST);
        chk({status_out_o, int_out_o}, 0);
        apb(0, OFS_SRC_CTRL, 0);
        chk(q, {24'h0, SRC_CTRL_RST});
        apb(0, OFS_PWR_CFG, 0);
        chk(q, {24'h0, PWR_CFG_RST});
        apb(0, 8'h10, 0);
        chk(serr, 1);
        chk(q, 32'h0);
        apb(1, OFS_STATUS, 32'hFFFF);
        chk(serr, 1);
        $display("registers done");
        // Full charge cycle, then recharge
        sense.vin_above_input_undervoltage_threshold <= 1'b1;
        sense.vin_below_ovp <= 1'b1;
        sense.vin_above_sleep <= 1'b1;
        sense.ts_in_window <= 1'b1;
        charge_req <= 1'b1;
        step(4);
        chk({input_good_out, ctrl.charge_en, status_out_oe}, 3'b011);
        apb(0, OFS_STATUS, 0);
        chk(q[14:12], 1);
        sense.bat_above_lowv <= 1'b1;
        apb(0, OFS_STATUS, 0);
        apb(0, OFS_STATUS, 0);
        chk(q[14:12], 2);
        sense.bat_at_reg <= 1'b1;
        apb(0, OFS_STATUS, 0);
        apb(0, OFS_STATUS, 0);
        chk(q[14:12], 3);
        sense.ichg_below_term <= 1'b1;
        apb(0, OFS_STATUS, 0);
        apb(0, OFS_STATUS, 0);
        chk({q[14:12], status_out_oe}, 4'h8);
        sense.ichg_below_term <= 1'b0;
        sense.bat_at_reg <= 1'b0;
        sense.bat_below_rechg <= 1'b1;
        step(4);
        chk(status_out_oe, 1);
        sense.bat_below_rechg <= 1'b0;
        sense.jtemp_over <= 1'b1;
        sense.in_limit_hit <= 1'b1;
        step(4);
        chk({ctrl.thermal_reduce, ctrl.chg_zero, ctrl.supplement}, 7);
        sense.jtemp_over <= 1'b0;
        sense.in_limit_hit <= 1'b0;
        charge_req <= 1'b0;
        step(4);
        chk({ctrl.charge_en, status_out_oe}, 0);
        charge_req <= 1'b1;
        for (int m = 0; m < 4; m++) begin
            apb(1, OFS_PWR_CFG, {26'h0, m[1:0], 4'hB});
            step(3);
            chk(ctrl.charge_en, m == 1);
        end
        charge_req <= 1'b0;
        $display("charge done");
        // Boost needs bit 4, pin and ts window
        for (int i = 0; i < 4; i++) begin
            limit_select_boost_pin <= i[0];
            sense.ts_in_window <= i[1];
            step(4);
            chk(ctrl.boost_en, i == 3);
        end
        apb(1, OFS_PWR_CFG, 32'h0B);
        step(3);
        chk(ctrl.boost_en, 0);
        $display("boost done");
        // Buck limits per source, field 7 and resistor 1500
        lim(0, 1, 1, USB_HI_MA);
        lim(0, 1, 0, USB_LO_MA);
        lim(0, 0, 1, 12'd1500);
        lim(1, 0, 1, USB_HI_MA);
        lim(1, 0, 0, USB_LO_MA);
        lim(2, 1, 1, 12'd1500);
        lim(3, 1, 0, 12'd1500);
        apb(1, OFS_SRC_CTRL, 32'h3);
        lim(2, 1, 1, 12'd900);
        input_limit_resistor_pin <= 12'h2BC;
        lim(2, 1, 1, 12'd700);
        $display("limits done");
        // Each window comparator alone spoils input good
        for (int i = 0; i < 3; i++) begin
            sense[10:8] <= 3'b111 ^ (3'b001 << i);
            step(4);
            chk(input_good_out, 1);
        end
        sense[10:8] <= 3'b111;
        input_limit_resistor_pin <= 12'd30;
        step(4);
        chk(input_good_out, 1);
        input_limit_resistor_pin <= 12'h2BC;
        $display("input good done");
        // Fault then input good: two pulses, the second queued
        host.clr();
        sense.fault <= 1'b1;
        step(60);
        chk(host.int_cnt, 2);
        chk(host.int_w, 4);
        chk(host.stat_edges >= 5, 1);
        sense.fault <= 1'b0;
        step(20);
        chk(status_line, 1);
        $display("fault done");
        // Shipping mode entry, short wake refused, long wake accepted
        apb(1, OFS_MISC_CTRL, 32'h20);
        step(2);
        chk(battery_switch, 0);
        host.wake(5);
        step(4);
        chk(battery_switch, 0);
        host.wake(14);
        chk(battery_switch, 1);
        $display("ship done");
        test_done();
    end
endmodule
`default_nettype wire
